// *** src/upc_defines.svh ***
// register offsets, field positions, reset values and line codes for the
// transceiver control block; definitions only, included by bare name
`ifndef UPC_DEFINES_SVH
`define UPC_DEFINES_SVH

// register byte offsets
`define UPC_OFF_EP_MARK      8'h34
`define UPC_OFF_OTG_MASK     8'h38
`define UPC_OFF_PWR_SIG      8'h3C
`define UPC_OFF_XCVR_CTRL    8'h40
`define UPC_OFF_IRQ_STAT     8'h44
`define UPC_OFF_IRQ_MASK     8'h48
`define UPC_OFF_SUSP_CTRL    8'h4C

// reset values
`define UPC_RST_ZERO32       32'h0000_0000

// endpoint marking
`define UPC_EP_MARK_W        16
`define UPC_RX_MARK_OFS      5'h10

// power signalling
`define UPC_PWR_VALID_BIT    8
`define UPC_PWR_DATA_MSB     7

// transceiver control fields
`define UPC_XC_PD_DIS_BIT    18
`define UPC_XC_RST_CAUSE_BIT 13
`define UPC_XC_RES_CAUSE_BIT 12
`define UPC_XC_FILT_MSB      11
`define UPC_XC_FILT_LSB      8
`define UPC_XC_AUTO_RES_BIT  7
`define UPC_XC_CONF_MSB      6
`define UPC_XC_CONF_LSB      4
`define UPC_XC_WMASK         32'h0004_3FF0

// interrupt status / mask bits
`define UPC_IRQ_W            4
`define UPC_IRQ_RST_CAUSE    0
`define UPC_IRQ_RES_CAUSE    1
`define UPC_IRQ_SUSPEND      2
`define UPC_IRQ_LINE_CHG     3

// suspend control fields
`define UPC_SC_WAKE_BIT      0
`define UPC_SC_LINE_MSB      1
`define UPC_SC_LINE_LSB      0
`define UPC_SC_SUSP_BIT      4

// filtered line state codes
`define UPC_LS_SE0           2'h0
`define UPC_LS_J             2'h1
`define UPC_LS_K             2'h2

// filter counter width, enough for 2**15 plus saturation
`define UPC_FILT_CNT_W       17
`define UPC_FILT_CNT_ONE     17'h0_0001

`endif

// *** src/upc_pkg.sv ***
// types shared by the transceiver control block
// assumes nothing beyond a SystemVerilog compiler
package upc_pkg;

    typedef logic [1:0] upc_line_t;

    // suspend controller states, one-hot
    typedef enum logic [1:0] {
        UPC_SUS_RUN   = 2'b01,
        UPC_SUS_SLEEP = 2'b10
    } upc_sus_state_t;

endpackage

// *** src/upc_line_filter.sv ***
// line-state filter: a change passes only after standing 2**log2Delay clocks
// assumes raw line state synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "upc_defines.svh"

module upc_line_filter
    import upc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      reset_n,
    input  wire upc_line_t lineRaw,
    input  wire logic [3:0] log2Delay,
    output logic           lineFilt,
    output upc_line_t      lineOut
);

    upc_line_t                    cand_r;
    upc_line_t                    cand_nxt;
    upc_line_t                    filt_r;
    upc_line_t                    filt_nxt;
    logic [`UPC_FILT_CNT_W-1:0]   cnt_r;
    logic [`UPC_FILT_CNT_W-1:0]   cnt_nxt;
    logic [`UPC_FILT_CNT_W-1:0]   target;
    logic                         chg_r;
    logic                         chg_nxt;

    // a glitch shorter than the window restarts the count and is dropped
    always_comb begin
        target   = `UPC_FILT_CNT_ONE << log2Delay;
        cand_nxt = cand_r;
        cnt_nxt  = cnt_r;
        filt_nxt = filt_r;
        chg_nxt  = 1'b0;
        if (lineRaw != cand_r) begin
            cand_nxt = lineRaw;
            cnt_nxt  = `UPC_FILT_CNT_ONE;
        end else if (cnt_r < target) begin
            cnt_nxt = cnt_r + `UPC_FILT_CNT_ONE;
        end
        if (lineRaw == cand_r && cnt_r >= target && cand_r != filt_r) begin
            filt_nxt = cand_r;
            chg_nxt  = 1'b1;
        end
    end

    // starts at J, the idle full-speed line
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cand_r <= `UPC_LS_J;
            filt_r <= `UPC_LS_J;
            cnt_r  <= '0;
            chg_r  <= 1'b0;
        end else begin
            cand_r <= cand_nxt;
            filt_r <= filt_nxt;
            cnt_r  <= cnt_nxt;
            chg_r  <= chg_nxt;
        end
    end

    assign lineOut  = filt_r;
    assign lineFilt = chg_r;

endmodule
`default_nettype wire

// *** src/upc_phy_ctrl.sv ***
// transceiver control and status registers behind an APB slave
// assumes one clock, synchronous transceiver inputs, zero-wait APB master
//
// Behaviour
// - a 16-bit writable endpoint marking field, one bit per endpoint, resets to zero, upper bits read zero.
// - a received endpoint whose marking bit is set is presented on the receive port ORed with 0x10.
// - control bit 18 set to one turns off the pulldowns on both data ports, which are on after reset.
// - an auto-resume caused by SE0 sets bit 13, held until software writes zero to it.
// - an auto-resume caused by K signalling sets bit 12, held until software writes zero to it.
// - any line-state change is propagated only after 2 to the power of the 4-bit filter field clocks.
// - with auto-resume enabled the suspend controller leaves suspend by itself on resume or reset signalling.
// - the three transceiver configuration pins follow a 3-bit writable field that resets to zero.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "upc_defines.svh"

module upc_phy_ctrl
    import upc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // receive side of the line interface
    input  wire logic              rxEpValid,
    input  wire logic [3:0]        rxEp,
    output logic                   rxPortValid,
    output logic [4:0]             rxPortEp,
    // transceiver line and pins
    input  wire upc_line_t         lineStateRaw,
    input  wire logic              suspendDetect,
    output logic                   suspendActive,
    output logic                   resumeStrobe,
    output logic [2:0]             transceiverConfigPins,
    output logic                   usbDataPortAPulldownEn,
    output logic                   usbDataPortBPulldownEn,
    // plain storage outputs
    output logic [31:0]            otgFlagMask,
    output logic [7:0]             powerSignalData,
    output logic                   powerSignalValid,
    // interrupt
    output logic                   irq
);

    // register state
    logic [`UPC_EP_MARK_W-1:0] epMark_r;
    logic [`UPC_EP_MARK_W-1:0] epMark_nxt;
    logic [31:0]               otgMask_r;
    logic [31:0]               otgMask_nxt;
    logic [8:0]                pwrSig_r;
    logic [8:0]                pwrSig_nxt;
    logic [31:0]               xcvrCtrl_r;
    logic [31:0]               xcvrCtrl_nxt;
    logic [`UPC_IRQ_W-1:0]     irqStat_r;
    logic [`UPC_IRQ_W-1:0]     irqStat_nxt;
    logic [`UPC_IRQ_W-1:0]     irqMask_r;
    logic [`UPC_IRQ_W-1:0]     irqMask_nxt;
    logic [31:0]               rdData_r;
    logic [31:0]               rdData_nxt;
    logic                      slvErr_r;
    logic                      slvErr_nxt;

    // receive port state
    logic                      rxValid_r;
    logic                      rxValid_nxt;
    logic [4:0]                rxEp_r;
    logic [4:0]                rxEp_nxt;

    // suspend controller state
    upc_sus_state_t            sus_r;
    upc_sus_state_t            sus_nxt;
    logic                      resume_r;
    logic                      resume_nxt;
    logic                      setRstCause;
    logic                      setResCause;
    logic                      enterSleep;

    // bus decode
    logic                      setupPhase;
    logic                      accessWr;
    logic                      mapped;
    logic                      softWake;

    // filtered line state
    upc_line_t                 lineFilt;
    logic                      lineChg;

    // line-state filter, delay set by the control field
    upc_line_filter u_filter (
        .clk       (clk),
        .reset_n   (reset_n),
        .lineRaw   (lineStateRaw),
        .log2Delay (xcvrCtrl_r[`UPC_XC_FILT_MSB:`UPC_XC_FILT_LSB]),
        .lineFilt  (lineChg),
        .lineOut   (lineFilt)
    );

    // address decode; every access completes without wait states
    always_comb begin
        setupPhase = psel && !penable;
        mapped     = 1'b0;
        case (paddr)
            `UPC_OFF_EP_MARK,
            `UPC_OFF_OTG_MASK,
            `UPC_OFF_PWR_SIG,
            `UPC_OFF_XCVR_CTRL,
            `UPC_OFF_IRQ_STAT,
            `UPC_OFF_IRQ_MASK,
            `UPC_OFF_SUSP_CTRL: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
        accessWr = psel && penable && pwrite && mapped;
        softWake = accessWr && (paddr == `UPC_OFF_SUSP_CTRL) && pwdata[`UPC_SC_WAKE_BIT];
    end

    assign pready  = 1'b1;
    assign prdata  = rdData_r;
    assign pslverr = slvErr_r;

    // read data captured in the setup cycle so it comes from a flop
    always_comb begin
        rdData_nxt = rdData_r;
        slvErr_nxt = 1'b0;
        if (setupPhase) begin
            slvErr_nxt = !mapped;
            rdData_nxt = `UPC_RST_ZERO32;
            if (!pwrite) begin
                case (paddr)
                    `UPC_OFF_EP_MARK:   rdData_nxt[`UPC_EP_MARK_W-1:0] = epMark_r;
                    `UPC_OFF_OTG_MASK:  rdData_nxt = otgMask_r;
                    `UPC_OFF_PWR_SIG:   rdData_nxt[`UPC_PWR_VALID_BIT:0] = pwrSig_r;
                    `UPC_OFF_XCVR_CTRL: rdData_nxt = xcvrCtrl_r;
                    `UPC_OFF_IRQ_STAT:  rdData_nxt[`UPC_IRQ_W-1:0] = irqStat_r;
                    `UPC_OFF_IRQ_MASK:  rdData_nxt[`UPC_IRQ_W-1:0] = irqMask_r;
                    `UPC_OFF_SUSP_CTRL: begin
                        rdData_nxt[`UPC_SC_LINE_MSB:`UPC_SC_LINE_LSB] = lineFilt;
                        rdData_nxt[`UPC_SC_SUSP_BIT] = (sus_r == UPC_SUS_SLEEP);
                    end
                    default:            rdData_nxt = `UPC_RST_ZERO32;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_r <= `UPC_RST_ZERO32;
            slvErr_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            slvErr_r <= slvErr_nxt;
        end
    end

    // suspend controller; without auto-resume only software wakes it
    always_comb begin
        sus_nxt     = sus_r;
        resume_nxt  = 1'b0;
        setRstCause = 1'b0;
        setResCause = 1'b0;
        enterSleep  = 1'b0;
        case (sus_r)
            UPC_SUS_RUN: begin
                if (suspendDetect) begin
                    sus_nxt    = UPC_SUS_SLEEP;
                    enterSleep = 1'b1;
                end
            end
            UPC_SUS_SLEEP: begin
                if (xcvrCtrl_r[`UPC_XC_AUTO_RES_BIT] && lineFilt == `UPC_LS_SE0) begin
                    sus_nxt     = UPC_SUS_RUN;
                    resume_nxt  = 1'b1;
                    setRstCause = 1'b1;
                end else if (xcvrCtrl_r[`UPC_XC_AUTO_RES_BIT] && lineFilt == `UPC_LS_K) begin
                    sus_nxt     = UPC_SUS_RUN;
                    resume_nxt  = 1'b1;
                    setResCause = 1'b1;
                end else if (softWake) begin
                    sus_nxt    = UPC_SUS_RUN;
                    resume_nxt = 1'b1;
                end
            end
            default: sus_nxt = UPC_SUS_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sus_r    <= UPC_SUS_RUN;
            resume_r <= 1'b0;
        end else begin
            sus_r    <= sus_nxt;
            resume_r <= resume_nxt;
        end
    end

    assign suspendActive = (sus_r == UPC_SUS_SLEEP);
    assign resumeStrobe  = resume_r;

    // software-written registers; cause bits are set by hardware too
    always_comb begin
        epMark_nxt   = epMark_r;
        otgMask_nxt  = otgMask_r;
        pwrSig_nxt   = pwrSig_r;
        xcvrCtrl_nxt = xcvrCtrl_r;
        irqMask_nxt  = irqMask_r;
        if (accessWr) begin
            case (paddr)
                `UPC_OFF_EP_MARK:   epMark_nxt = pwdata[`UPC_EP_MARK_W-1:0];
                `UPC_OFF_OTG_MASK:  otgMask_nxt = pwdata;
                `UPC_OFF_PWR_SIG:   pwrSig_nxt = pwdata[`UPC_PWR_VALID_BIT:0];
                `UPC_OFF_XCVR_CTRL: xcvrCtrl_nxt = pwdata & `UPC_XC_WMASK;
                `UPC_OFF_IRQ_MASK:  irqMask_nxt = pwdata[`UPC_IRQ_W-1:0];
                default:            irqMask_nxt = irqMask_r;
            endcase
        end
        // set after the write so a same-cycle clear cannot win
        if (setRstCause) begin
            xcvrCtrl_nxt[`UPC_XC_RST_CAUSE_BIT] = 1'b1;
        end
        if (setResCause) begin
            xcvrCtrl_nxt[`UPC_XC_RES_CAUSE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            epMark_r   <= '0;
            otgMask_r  <= `UPC_RST_ZERO32;
            pwrSig_r   <= '0;
            xcvrCtrl_r <= `UPC_RST_ZERO32;
            irqMask_r  <= '0;
        end else begin
            epMark_r   <= epMark_nxt;
            otgMask_r  <= otgMask_nxt;
            pwrSig_r   <= pwrSig_nxt;
            xcvrCtrl_r <= xcvrCtrl_nxt;
            irqMask_r  <= irqMask_nxt;
        end
    end

    // transceiver pins straight from the control register
    assign transceiverConfigPins  = xcvrCtrl_r[`UPC_XC_CONF_MSB:`UPC_XC_CONF_LSB];
    assign usbDataPortAPulldownEn = !xcvrCtrl_r[`UPC_XC_PD_DIS_BIT];
    assign usbDataPortBPulldownEn = !xcvrCtrl_r[`UPC_XC_PD_DIS_BIT];
    assign otgFlagMask            = otgMask_r;
    assign powerSignalData        = pwrSig_r[`UPC_PWR_DATA_MSB:0];
    assign powerSignalValid       = pwrSig_r[`UPC_PWR_VALID_BIT];

    // sticky interrupt status, write one to clear, set wins
    always_comb begin
        irqStat_nxt = irqStat_r;
        if (accessWr && paddr == `UPC_OFF_IRQ_STAT) begin
            irqStat_nxt = irqStat_r & ~pwdata[`UPC_IRQ_W-1:0];
        end
        if (setRstCause) begin
            irqStat_nxt[`UPC_IRQ_RST_CAUSE] = 1'b1;
        end
        if (setResCause) begin
            irqStat_nxt[`UPC_IRQ_RES_CAUSE] = 1'b1;
        end
        if (enterSleep) begin
            irqStat_nxt[`UPC_IRQ_SUSPEND] = 1'b1;
        end
        if (lineChg) begin
            irqStat_nxt[`UPC_IRQ_LINE_CHG] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStat_r <= '0;
        end else begin
            irqStat_r <= irqStat_nxt;
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    // receive port; marked endpoints carry the offset bit
    always_comb begin
        rxValid_nxt = rxEpValid;
        rxEp_nxt    = rxEp_r;
        if (rxEpValid) begin
            rxEp_nxt = {1'b0, rxEp};
            if (epMark_r[rxEp]) begin
                rxEp_nxt = {1'b0, rxEp} | `UPC_RX_MARK_OFS;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxValid_r <= 1'b0;
            rxEp_r    <= '0;
        end else begin
            rxValid_r <= rxValid_nxt;
            rxEp_r    <= rxEp_nxt;
        end
    end

    assign rxPortValid = rxValid_r;
    assign rxPortEp    = rxEp_r;

endmodule
`default_nettype wire

// *** test/upc_phy_ctrl_assertions.sv ***
// port checker for the transceiver control block
// assumes binding into upc_phy_ctrl, one clock
`timescale 1ns/100ps
`default_nettype none
`include "upc_defines.svh"
module upc_phy_ctrl_checker
    import upc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              rxEpValid,
    input wire logic [3:0]        rxEp,
    input wire logic              rxPortValid,
    input wire logic [4:0]        rxPortEp,
    input wire logic              suspendDetect,
    input wire logic              suspendActive,
    input wire logic              resumeStrobe,
    input wire logic [2:0]        transceiverConfigPins,
    input wire logic              usbDataPortAPulldownEn,
    input wire logic              usbDataPortBPulldownEn,
    input wire logic [7:0]        powerSignalData,
    input wire logic              powerSignalValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // access-edge write and setup-edge decode
    logic wrCtl;
    logic setup;
    logic mapped;
    assign wrCtl  = psel && penable && pwrite && paddr == `UPC_OFF_XCVR_CTRL;
    assign setup  = psel && !penable;
    assign mapped = paddr[1:0] == 2'h0 && paddr >= `UPC_OFF_EP_MARK && paddr <= `UPC_OFF_SUSP_CTRL;

    a_ready_tied: assert property (pready) else $error("pready low");
    a_rx_follow: assert property (1'b1 |=> rxPortValid == $past(rxEpValid)) else $error("rx valid lag");
    a_rx_ep_copy: assert property (rxEpValid |=> rxPortEp[3:0] == $past(rxEp)) else $error("rx ep");
    a_pd_pair: assert property (usbDataPortAPulldownEn == usbDataPortBPulldownEn) else $error("pd pair");
    a_pd_write: assert property (wrCtl |=> usbDataPortAPulldownEn == !$past(pwdata[18])) else $error("pd");
    a_conf_write: assert property (wrCtl |=> transceiverConfigPins == $past(pwdata[6:4])) else $error("conf");
    a_conf_hold: assert property (!wrCtl |=> $stable(transceiverConfigPins)) else $error("conf moved");
    a_mark_rsvd: assert property (setup && !pwrite && paddr == `UPC_OFF_EP_MARK |=> prdata[31:16] == 16'h0000)
        else $error("mark rsvd");
    a_pwr_write: assert property (psel && penable && pwrite && paddr == `UPC_OFF_PWR_SIG
        |=> {powerSignalValid, powerSignalData} == $past(pwdata[8:0])) else $error("pwr");
    a_unmapped_err: assert property (setup && !mapped |=> pslverr) else $error("no pslverr");
    a_resume_pulse: assert property ($fell(suspendActive) |-> resumeStrobe ##1 !resumeStrobe)
        else $error("resume pulse");
    a_susp_enter: assert property (suspendDetect && !suspendActive |=> suspendActive) else $error("suspend");
    c_rx_stream: cover property (rxEpValid [*2]);
    c_resume: cover property ($fell(suspendActive));
    c_slverr: cover property (pslverr);
endmodule

bind upc_phy_ctrl upc_phy_ctrl_checker #(.ADDR_W(ADDR_W)) i_chk (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .rxEpValid, .rxEp, .rxPortValid, .rxPortEp, .suspendDetect,
    .suspendActive, .resumeStrobe, .transceiverConfigPins, .usbDataPortAPulldownEn, .usbDataPortBPulldownEn,
    .powerSignalData, .powerSignalValid);
`default_nettype wire

// *** test/upc_xcvr_model.sv ***
// transceiver stand-in: raw line state and suspend flag
// assumes commands from the bench on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "upc_defines.svh"
module upc_xcvr_model
    import upc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      reset_n,
    input  wire upc_line_t lineCmd,
    input  wire logic      suspCmd,
    output upc_line_t      lineStateRaw,
    output logic           suspendDetect
);
    // line idles at J, as the pull-up leaves it; one cycle of line delay
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineStateRaw  <= `UPC_LS_J;
            suspendDetect <= 1'b0;
        end else begin
            lineStateRaw  <= lineCmd;
            suspendDetect <= suspCmd;
        end
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for upc_phy_ctrl
// assumes the transceiver stand-in and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "upc_defines.svh"
module tb_top;
    import upc_pkg::*;
    localparam logic [7:0] A_CTL = `UPC_OFF_XCVR_CTRL;
    localparam logic [7:0] A_STA = `UPC_OFF_IRQ_STAT;
    localparam logic [7:0] A_SUS = `UPC_OFF_SUSP_CTRL;
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxEpValid;
    logic [3:0]  rxEp;
    logic        rxPortValid;
    logic [4:0]  rxPortEp;
    upc_line_t   lineCmd;
    upc_line_t   lineRaw;
    logic        suspCmd;
    logic        suspDet;
    logic        suspAct;
    logic        resStb;
    logic [2:0]  cfgPins;
    logic        pdA;
    logic        pdB;
    logic [31:0] otgMask;
    logic [7:0]  pwrData;
    logic        pwrValid;
    logic        irq;
    logic [31:0] mCtl;
    logic [31:0] mMark;
    logic [31:0] v;
    int          bad_count;
    int          n_compared;
    int          k;

    upc_phy_ctrl i_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .rxEpValid, .rxEp, .rxPortValid, .rxPortEp, .lineStateRaw(lineRaw), .suspendDetect(suspDet),
        .suspendActive(suspAct), .resumeStrobe(resStb), .transceiverConfigPins(cfgPins),
        .usbDataPortAPulldownEn(pdA), .usbDataPortBPulldownEn(pdB), .otgFlagMask(otgMask),
        .powerSignalData(pwrData), .powerSignalValid(pwrValid), .irq);
    upc_xcvr_model i_xcvr (.clk, .reset_n, .lineCmd, .suspCmd, .lineStateRaw(lineRaw), .suspendDetect(suspDet));

    task automatic summarize();
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask
    // one APB transfer; waits on pready under a bound
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            summarize();
        end
        r = prdata;
        check("pslverr", 32'(a > A_SUS || a < 8'h34), 32'(pslverr));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
        @(negedge clk);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(a, 1'b0, 32'h0000_0000, r);
        check(nm, exp, r);
    endtask
    task automatic line(input upc_line_t s, input int n);
        @(posedge clk);
        lineCmd <= s;
        repeat (n) @(posedge clk);
    endtask
    task automatic suspend();
        @(posedge clk);
        suspCmd <= 1'b1;
        @(posedge clk);
        suspCmd <= 1'b0;
        repeat (3) @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, rxEpValid, rxEp, suspCmd} = '0;
        lineCmd    = `UPC_LS_J;
        bad_count  = 0;
        n_compared = 0;
        v = $urandom(32'hE3B4);
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("pdA", 1, pdA);
        check("cfg", 0, cfgPins);
        rd("mark0", 8'h34, 0);
        rd("ctl0", A_CTL, 0);
        rd("unmapped", 8'h50, 0);
        v = $urandom;
        wr(8'h38, v);
        check("otg", v, otgMask);
        rd("otgRd", 8'h38, v);
        wr(8'h3C, v);
        check("pwr", v[8:0], {pwrValid, pwrData});
        rd("pwrRd", 8'h3C, v & 32'h1FF);
        // endpoint marking, all sixteen endpoints streamed
        mMark = $urandom & 32'hFFFF;
        wr(8'h34, 32'hFFFF_0000 | mMark);
        rd("mark", 8'h34, mMark);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            rxEpValid <= 1'b1;
            rxEp      <= 4'(i);
            repeat (2) @(negedge clk);
            check("rxEp", mMark[i] ? i | 16 : i, rxPortEp);
            check("rxValid", 1, rxPortValid);
        end
        @(posedge clk);
        rxEpValid <= 1'b0;
        // config pins and pulldowns, reserved bits written as ones
        for (int i = 0; i < 8; i++) begin
            mCtl = 32'h0300 | (i << 4) | (($urandom & 1) << 18);
            wr(A_CTL, mCtl | 32'hFFFB_C00F);
            check("cfg", i, cfgPins);
            check("pdB", !mCtl[18], pdB);
            rd("ctl", A_CTL, mCtl);
        end
        // filter of 8 clocks: short glitch dropped, steady change passes
        wr(`UPC_OFF_IRQ_MASK, 32'h8);
        line(`UPC_LS_K, 5);
        line(`UPC_LS_J, 20);
        rd("glitch", A_SUS, `UPC_LS_J);
        line(`UPC_LS_K, 0);
        rd("early", A_SUS, `UPC_LS_J);
        repeat (12) @(negedge clk);
        rd("late", A_SUS, `UPC_LS_K);
        check("irq", 1, irq);
        rd("sta", A_STA, 32'h8);
        wr(`UPC_OFF_IRQ_MASK, 32'hF);
        wr(A_STA, 32'hF);
        check("irqClr", 0, irq);
        // auto-resume off: software polls the filtered line, then wakes
        line(`UPC_LS_J, 12);
        suspend();
        line(`UPC_LS_K, 12);
        check("stay", 1, suspAct);
        rd("poll", A_SUS, 32'h10 | `UPC_LS_K);
        wr(A_SUS, 32'h1);
        check("woke", 0, suspAct);
        rd("noCause", A_CTL, mCtl);
        // auto-resume on: K then SE0
        mCtl = mCtl | 32'h80;
        wr(A_CTL, mCtl);
        for (int c = 0; c < 2; c++) begin
            line(`UPC_LS_J, 12);
            wr(A_STA, 32'hF);
            suspend();
            line(c ? `UPC_LS_SE0 : `UPC_LS_K, 0);
            // filter of 8 puts the resume on the 11th edge; the write of zero lands on it
            repeat (8) @(posedge clk);
            wr(A_CTL, mCtl);
            k = 0;
            while (suspAct === 1'b1 && k < 40) begin
                @(negedge clk);
                k++;
            end
            check("resumed", 0, suspAct);
            mCtl = mCtl | (c ? 32'h2000 : 32'h1000);
            rd("cause", A_CTL, mCtl);
            rd("staRes", A_STA, c ? 32'hD : 32'hE);
            check("irqRes", 1, irq);
            repeat (5) @(negedge clk);
            rd("held", A_CTL, mCtl);
            mCtl = mCtl & 32'hFFFF_CFFF;
            wr(A_CTL, mCtl);
            rd("cleared", A_CTL, mCtl);
        end
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
